//--- logic/chs_charger_ctrl.sv
/*
  Control logic of a single-cell linear charger: pack temperature
  qualification, power-good and charge status pins, current phase select,
  pre-charge safety timer with its fault latch, thermal reaction, and an
  AHB-Lite register slave.
  Assumes all comparator inputs are levels from the analog side, a single
  clock hclk, and an external wire resolver for the open-drain pins.
  Timer figures are counted in hclk cycles.

*/
`timescale 1ns/1ps
`default_nettype none
`include "chs_params.svh"

module chs_charger_ctrl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // host and analog inputs
  input wire logic charge_enable_n,
  input wire chs_pkg::chs_cmp_t cmp,
  // power stage commands
  output chs_pkg::chs_drive_t drive,
  // open-drain pins
  output chs_pkg::chs_od_t input_power_ok_out,
  output chs_pkg::chs_od_t status_line_a,
  output chs_pkg::chs_od_t status_line_b
);

  chs_pkg::chs_state_t st;
  chs_pkg::chs_state_t next_st;

  always_comb
  begin
    logic in_ok;
    logic input_overvolt_flag;
    logic cen;
    logic temp_ok;
    logic above;
    logic term_off;
    logic timer_open;
    logic [31:0] plimit;
    logic clr_fault;
    logic set_fault;
    logic a_on;
    logic b_on;
    chs_pkg::chs_status_t stat;
    logic cen_rise;
    logic done_code;
    logic stage_ok;
    in_ok = 1'b0;
    input_overvolt_flag = 1'b0;
    cen = 1'b1;
    temp_ok = 1'b0;
    above = 1'b0;
    term_off = 1'b0;
    timer_open = 1'b0;
    plimit = 32'h0000_0000;
    clr_fault = 1'b0;
    set_fault = 1'b0;
    a_on = 1'b0;
    b_on = 1'b0;
    stat = '0;
    cen_rise = 1'b0;
    done_code = 1'b0;
    stage_ok = 1'b0;
    next_st = st;

    // two-stage synchronisers
    next_st.sync1 = cmp;
    next_st.sync2 = st.sync1;
    next_st.cen_s1 = charge_enable_n;
    next_st.cen_s2 = st.cen_s1;
    next_st.cen_prev = st.cen_s2;

    in_ok = st.sync2.input_detect;
    input_overvolt_flag = st.sync2.input_ovp;
    cen = st.cen_s2;
    temp_ok = !st.sync2.temp_cold && !st.sync2.temp_hot;
    above = st.sync2.above_lowv;
    timer_open = st.ctrl.timer_open;
    term_off = timer_open || st.ctrl.term_enable_n;
    cen_rise = cen && !st.cen_prev;
    done_code = st.sync2.term_done && !term_off;
    // stage goes off on the same edge the mode enters suspend after the pack or junction goes bad
    stage_ok = temp_ok && !st.sync2.tj_shut;

    // mode selection
    if (!in_ok)
    begin
      next_st.mode = chs_pkg::chs_sleep;
    end
    else if (input_overvolt_flag || cen)
    begin
      next_st.mode = chs_pkg::chs_standby;
    end
    else if (st.fault)
    begin
      next_st.mode = chs_pkg::chs_fault;
    end
    else if (!temp_ok || st.sync2.tj_shut)
    begin
      next_st.mode = chs_pkg::chs_suspend;
    end
    else
    begin
      next_st.mode = chs_pkg::chs_charging;
    end

    // pre-charge safety timer
    plimit = 32'(`CHS_PCHG_FACTOR * st.ftime);
    case (st.mode)
      chs_pkg::chs_charging:
      begin
        if (above || timer_open)
        begin
          next_st.pcount = 32'h0000_0000;
        end
        else if (st.pcount >= plimit)
        begin
          set_fault = 1'b1;
        end
        else
        begin
          next_st.pcount = st.pcount + 32'h0000_0001;
        end
      end
      chs_pkg::chs_suspend:
      begin
        if (above || timer_open)
        begin
          next_st.pcount = 32'h0000_0000;
        end
        else
        begin
          next_st.pcount = st.pcount;
        end
      end
      chs_pkg::chs_standby:
      begin
        next_st.pcount = 32'h0000_0000;
      end
      chs_pkg::chs_sleep:
      begin
        next_st.pcount = 32'h0000_0000;
      end
      chs_pkg::chs_fault:
      begin
        next_st.pcount = 32'h0000_0000;
      end
      default:
      begin
        next_st.pcount = 32'h0000_0000;
      end
    endcase

    // fault latch: set wins over clear
    clr_fault = cen_rise || input_overvolt_flag || !in_ok || timer_open || above;
    if (set_fault)
    begin
      next_st.fault = 1'b1;
    end
    else if (clr_fault)
    begin
      next_st.fault = 1'b0;
    end

    // power stage commands
    next_st.drive = '0;
    next_st.drive.thermal_shutdown = st.sync2.tj_shut;
    next_st.drive.trickle_en = st.fault && in_ok && !above;
    case (st.mode)
      chs_pkg::chs_charging:
      begin
        if (!st.fault && !set_fault && stage_ok && !done_code)
        begin
          next_st.drive.power_on = 1'b1;
          next_st.drive.fast_sel = above;
          next_st.drive.pre_sel = !above;
          next_st.drive.vreg_phase = st.sync2.at_reg;
          next_st.drive.current_reduce = st.sync2.junction_reg_temp;
        end
      end
      default:
      begin
        // standby, suspend, fault and sleep keep the stage off
        next_st.drive.power_on = 1'b0;
      end
    endcase

    // status line codes
    case (st.mode)
      chs_pkg::chs_charging:
      begin
        if (!st.sync2.batt_absent && !st.sync2.batt_short)
        begin
          if (done_code)
          begin
            b_on = 1'b1;
          end
          else if (above)
          begin
            a_on = 1'b1;
          end
          else
          begin
            a_on = 1'b1;
            b_on = 1'b1;
          end
        end
      end
      default:
      begin
        // suspend, fault, standby and sleep all show off/off
        a_on = 1'b0;
        b_on = 1'b0;
      end
    endcase
    next_st.sa.out = 1'b0;
    next_st.sb.out = 1'b0;
    next_st.sa.oe = in_ok && a_on;
    next_st.sb.oe = in_ok && b_on;
    next_st.pg.out = 1'b0;
    next_st.pg.oe = in_ok && !input_overvolt_flag;

    // ahb-lite data phase write
    if (st.wr_pend)
    begin
      if (st.wr_addr == `CHS_ADDR_CTRL)
      begin
        next_st.ctrl.timer_open = hwdata[0];
        next_st.ctrl.term_enable_n = hwdata[1];
      end
      else if (st.wr_addr == `CHS_ADDR_FTIME)
      begin
        next_st.ftime = hwdata;
      end
    end

    // ahb-lite address phase
    stat.mode = st.mode;
    stat.fault = st.fault;
    stat.input_detect = in_ok;
    stat.input_ovp = input_overvolt_flag;
    stat.temp_ok = temp_ok;
    stat.above_lowv = above;
    stat.power_on = st.drive.power_on;
    stat.vreg_phase = st.drive.vreg_phase;
    stat.trickle_en = st.drive.trickle_en;
    stat.tj_shut = st.sync2.tj_shut;
    next_st.wr_pend = 1'b0;
    next_st.rdata = 32'h0000_0000;
    next_st.ready = 1'b1;
    if (hsel && htrans[1] && hready)
    begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = haddr;
      if (!hwrite)
      begin
        if (haddr == `CHS_ADDR_CTRL)
        begin
          next_st.rdata = st.ctrl;
        end
        else if (haddr == `CHS_ADDR_FTIME)
        begin
          next_st.rdata = st.ftime;
        end
        else if (haddr == `CHS_ADDR_STATUS)
        begin
          next_st.rdata = stat;
        end
        else if (haddr == `CHS_ADDR_PCOUNT)
        begin
          next_st.rdata = st.pcount;
        end
        else
        begin
          // unmapped reads return zero
          next_st.rdata = 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
      st.cen_s1 <= 1'b1;
      st.cen_s2 <= 1'b1;
      st.cen_prev <= 1'b1;
      st.mode <= chs_pkg::chs_sleep;
      st.ctrl <= `CHS_CTRL_RESET;
      st.ftime <= `CHS_FTIME_RESET;
      st.ready <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign hreadyout = st.ready;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign drive = st.drive;
  assign input_power_ok_out = st.pg;
  assign status_line_a = st.sa;
  assign status_line_b = st.sb;

endmodule

`default_nettype wire

//--- logic/chs_params.svh
/*
  Constants of the charger status and pre-charge timer block: register byte
  addresses, reset values and timer figures.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef CHS_PARAMS_SVH
`define CHS_PARAMS_SVH

// register byte addresses
`define CHS_ADDR_CTRL 32'h0000_0000
`define CHS_ADDR_FTIME 32'h0000_0004
`define CHS_ADDR_STATUS 32'h0000_0008
`define CHS_ADDR_PCOUNT 32'h0000_000c

// reset values
`define CHS_CTRL_RESET 32'h0000_0000
`define CHS_FTIME_RESET 32'h0000_0800

// pre-charge timeout is this factor times the fast-charge timeout
`define CHS_PCHG_FACTOR 32'h0000_000a

`endif

//--- logic/chs_pkg.sv
/*
  Types of the charger status and pre-charge timer block.
  Assumes nothing of its surroundings.
*/
package chs_pkg;

  // operating modes, one-hot
  typedef enum logic [4:0] {
    chs_sleep    = 5'h01,
    chs_standby  = 5'h02,
    chs_charging = 5'h04,
    chs_suspend  = 5'h08,
    chs_fault    = 5'h10
  } chs_mode_t;

  // comparator and detector levels from the analog side
  typedef struct packed {
    logic input_detect;
    logic input_ovp;
    logic temp_cold;
    logic temp_hot;
    logic above_lowv;
    logic at_reg;
    logic junction_reg_temp;
    logic tj_shut;
    logic batt_absent;
    logic batt_short;
    logic term_done;
  } chs_cmp_t;

  // open-drain pin: out is always low, oe high while pulling down
  typedef struct packed {
    logic out;
    logic oe;
  } chs_od_t;

  // commands to the analog power stage
  typedef struct packed {
    logic power_on;
    logic fast_sel;
    logic pre_sel;
    logic vreg_phase;
    logic trickle_en;
    logic current_reduce;
    logic thermal_shutdown;
  } chs_drive_t;

  typedef struct packed {
    logic [29:0] rsvd;
    logic term_enable_n;
    logic timer_open;
  } chs_ctrl_t;

  typedef struct packed {
    logic [17:0] rsvd;
    logic tj_shut;
    logic trickle_en;
    logic vreg_phase;
    logic power_on;
    logic above_lowv;
    logic temp_ok;
    logic input_ovp;
    logic input_detect;
    logic fault;
    chs_mode_t mode;
  } chs_status_t;

  // whole state of the block
  typedef struct packed {
    chs_cmp_t sync1;
    chs_cmp_t sync2;
    logic cen_s1;
    logic cen_s2;
    logic cen_prev;
    chs_mode_t mode;
    logic fault;
    logic [31:0] pcount;
    chs_ctrl_t ctrl;
    logic [31:0] ftime;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    chs_drive_t drive;
    chs_od_t pg;
    chs_od_t sa;
    chs_od_t sb;
  } chs_state_t;

endpackage

//--- sim/chs_asserts.sv
/*
  Port checker for the charger control block.
  Assumes binding to chs_charger_ctrl; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module chs_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire chs_pkg::chs_cmp_t cmp,
  input wire chs_pkg::chs_drive_t drive,
  input wire chs_pkg::chs_od_t input_power_ok_out,
  input wire chs_pkg::chs_od_t status_line_a,
  input wire chs_pkg::chs_od_t status_line_b
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_in_ok;
    (cmp.input_detect && !cmp.input_ovp) [*5];
  endsequence
  sequence s_ovp;
    (cmp.input_detect && cmp.input_ovp) [*5];
  endsequence
  sequence s_no_in;
    (!cmp.input_detect) [*5];
  endsequence
  sequence s_temp_bad;
    (cmp.temp_hot || cmp.temp_cold) [*5];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  a_od_low: assert property (!input_power_ok_out.out && !status_line_a.out && !status_line_b.out)
    else $error("open-drain pin drives high");
  a_pok_on: assert property (s_in_ok |=> input_power_ok_out.oe)
    else $error("power ok not pulled low");
  a_ovp_off: assert property (s_ovp |=> !input_power_ok_out.oe && !drive.power_on)
    else $error("overvoltage left stage or power ok on");
  a_sleep_off: assert property (s_no_in |=> !status_line_a.oe && !status_line_b.oe && !drive.power_on)
    else $error("no input but pins or stage on");
  a_temp_off: assert property (s_temp_bad |=> !drive.power_on)
    else $error("stage on with pack temperature bad");
  a_fault_off: assert property (drive.trickle_en |-> !drive.power_on)
    else $error("stage on while trickle on");
  a_shut_off: assert property (drive.thermal_shutdown |-> !drive.power_on)
    else $error("stage on in thermal shutdown");
  a_phase_one: assert property (drive.power_on |-> drive.fast_sel != drive.pre_sel)
    else $error("current phase select ambiguous");
endmodule
bind chs_charger_ctrl chs_asserts i_chs_asserts (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .cmp(cmp), .drive(drive), .input_power_ok_out(input_power_ok_out),
  .status_line_a(status_line_a), .status_line_b(status_line_b));
`default_nettype wire

//--- sim/chs_pin_model.sv
/*
  Host side of the open-drain pins: pull-ups give the seen levels.
  Assumes out/oe pairs from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module chs_pin_model (
  // pins from the block
  input wire chs_pkg::chs_od_t pok,
  input wire chs_pkg::chs_od_t sa,
  input wire chs_pkg::chs_od_t sb,
  // levels seen by the host
  output logic pok_lvl,
  output logic sa_lvl,
  output logic sb_lvl
);
  // released pin floats up to the pull-up level
  assign pok_lvl = pok.oe ? pok.out : 1'b1;
  assign sa_lvl = sa.oe ? sa.out : 1'b1;
  assign sb_lvl = sb.oe ? sb.out : 1'b1;
endmodule
`default_nettype wire

//--- sim/chs_charger_ctrl_tb.sv
/*
  Self-checking bench of the charger control block.
  Assumes the checker is bound and the pin model resolves the pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "chs_params.svh"
module chs_charger_ctrl_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, pok_lvl, sa_lvl, sb_lvl;
  logic [31:0] hrdata, q1, q2;
  logic charge_enable_n = 1'b0;
  chs_pkg::chs_cmp_t cmp = '0;
  chs_pkg::chs_drive_t drive;
  chs_pkg::chs_od_t pok, sa, sb;
  int fail_count = 0;
  int num_checks = 0;
  always #50 hclk = ~hclk;
  chs_charger_ctrl i_chs_charger_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .charge_enable_n(charge_enable_n),
    .cmp(cmp), .drive(drive), .input_power_ok_out(pok), .status_line_a(sa), .status_line_b(sb));
  chs_pin_model i_chs_pin_model (.pok(pok), .sa(sa), .sb(sb), .pok_lvl(pok_lvl), .sa_lvl(sa_lvl),
    .sb_lvl(sb_lvl));
  task automatic conclude();
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // wait for hready with a bound
  task automatic hold();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hold();
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    q = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q1);
  endtask
  // settle then compare {power ok, line a, line b, stage} levels
  task automatic pins(input int n, input logic [3:0] e);
    cyc(n);
    @(negedge hclk);
    chk({28'h0, pok_lvl, sa_lvl, sb_lvl, drive.power_on}, {28'h0, e});
  endtask
  task automatic wait_fault();
    int k;
    k = 0;
    while (drive.trickle_en !== 1'b1 && k < 300)
    begin
      @(posedge hclk);
      k++;
    end
    if (k >= 300)
    begin
      fail_count++;
      conclude();
    end
  endtask
  initial
  begin
    cyc(2);
    hresetn <= 1'b1;
    cyc(5);
    rd(`CHS_ADDR_CTRL, `CHS_CTRL_RESET);
    rd(`CHS_ADDR_FTIME, `CHS_FTIME_RESET);
    rd(`CHS_ADDR_STATUS, 32'h101);
    rd(32'h10, 32'h0);
    wr(`CHS_ADDR_FTIME, 32'h4);
    cmp.input_detect <= 1'b1;
    pins(6, 4'h1);
    chk({drive.fast_sel, drive.pre_sel}, 2'b01);
    cyc(10);
    cmp.temp_hot <= 1'b1;
    pins(6, 4'h6);
    xfer(1'b0, `CHS_ADDR_PCOUNT, 32'h0, q1);
    cyc(5);
    xfer(1'b0, `CHS_ADDR_PCOUNT, 32'h0, q2);
    chk(q2, q1);
    cmp.temp_hot <= 1'b0;
    pins(6, 4'h1);
    xfer(1'b0, `CHS_ADDR_PCOUNT, 32'h0, q2);
    chk(q2 > q1, 1);
    wait_fault();
    pins(2, 4'h6);
    rd(`CHS_ADDR_STATUS, 32'h1170);
    cmp.above_lowv <= 1'b1;
    pins(6, 4'h3);
    chk({drive.fast_sel, drive.pre_sel}, 2'b10);
    rd(`CHS_ADDR_PCOUNT, 32'h0);
    cmp.at_reg <= 1'b1;
    cmp.junction_reg_temp <= 1'b1;
    pins(6, 4'h3);
    chk({drive.vreg_phase, drive.current_reduce}, 2'b11);
    cmp.tj_shut <= 1'b1;
    pins(6, 4'h6);
    chk(drive.thermal_shutdown, 1'b1);
    cmp.tj_shut <= 1'b0;
    cmp.term_done <= 1'b1;
    pins(6, 4'h4);
    for (int i = 2; i > 0; i--)
    begin
      wr(`CHS_ADDR_CTRL, 32'(i));
      pins(6, 4'h3);
    end
    cmp.above_lowv <= 1'b0;
    pins(6, 4'h1);
    rd(`CHS_ADDR_PCOUNT, 32'h0);
    wr(`CHS_ADDR_CTRL, 32'h0);
    cmp.term_done <= 1'b0;
    wait_fault();
    charge_enable_n <= 1'b1;
    pins(6, 4'h6);
    rd(`CHS_ADDR_PCOUNT, 32'h0);
    charge_enable_n <= 1'b0;
    pins(6, 4'h1);
    cmp.batt_absent <= 1'b1;
    pins(6, 4'h7);
    cmp.batt_absent <= 1'b0;
    cmp.batt_short <= 1'b1;
    pins(6, 4'h7);
    cmp.batt_short <= 1'b0;
    cmp.input_ovp <= 1'b1;
    pins(6, 4'he);
    cmp.input_ovp <= 1'b0;
    pins(6, 4'h1);
    cmp.input_detect <= 1'b0;
    pins(6, 4'he);
    conclude();
  end
endmodule
`default_nettype wire
